//--- common/irq_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries set and clear requests to the event flag store and its contents
// back to the register logic.
interface irq_flag_if;
   // Bits to set this cycle, one per event.
   logic [irq_mask_pkg::DATA_W-1:0] set_vec;
   // Bits to clear this cycle, requested by software.
   logic [irq_mask_pkg::DATA_W-1:0] clr_vec;
   // Synchronous software reset of all flags.
   logic soft_clr;
   // Clock enable; all state holds while it is low.
   logic ce;
   // Present flag contents.
   logic [irq_mask_pkg::DATA_W-1:0] flags;

   // The register logic drives requests and reads flags.
   modport owner (output set_vec, output clr_vec, output soft_clr,
                  output ce, input flags);
   // The store takes requests and shows its flags.
   modport store (input set_vec, input clr_vec, input soft_clr,
                  input ce, output flags);
endinterface : irq_flag_if
`default_nettype wire

//--- common/irq_mask_pkg.sv
// Overview of operation
// - Interrupt needs flag, enable bit and master gate.
// - Set-style write sets enables where data is one.
// - Set-style read returns shared mask with master gate.
// - Clear-style write clears enables where data is one.
// - Clear-style read returns the same shared mask.
// - Command codes 04/84 set-style, 05/85 clear-style.
// - Bit 31 one via set-style enables master gate.
// - Bit 31 one via clear-style blocks all interrupts.
// - Enables at bits 6,5,4,3,2,0 match event flags.
// - Bits 1, 7 and 8 to 30 reserved.
// - Hardware or software reset leaves everything cleared.
// - Device sets event flags, never clears them itself.
package irq_mask_pkg;

   // Width of the register data path.
   localparam int DATA_W = 32;
   // Width of a command code on the register port.
   localparam int CMD_W = 8;

   // Command codes of the event status register.
   localparam logic [CMD_W-1:0] CMD_EVENT_RD = 8'h03;
   localparam logic [CMD_W-1:0] CMD_EVENT_WR = 8'h83;
   // Command codes of the set-style mask register.
   localparam logic [CMD_W-1:0] CMD_MASK_SET_RD = 8'h04;
   localparam logic [CMD_W-1:0] CMD_MASK_SET_WR = 8'h84;
   // Command codes of the clear-style mask register.
   localparam logic [CMD_W-1:0] CMD_MASK_CLR_RD = 8'h05;
   localparam logic [CMD_W-1:0] CMD_MASK_CLR_WR = 8'h85;

   // Bit positions of the master gate and the per-event fields.
   localparam int MASTER_IRQ_GATE_BIT = 31;
   localparam int HUB_CHANGE_BIT = 6;
   localparam int FRAME_WRAP_BIT = 5;
   localparam int FATAL_ERROR_BIT = 4;
   localparam int RESUME_DETECT_BIT = 3;
   localparam int FRAME_BEGIN_BIT = 2;
   localparam int OVERRUN_BIT = 0;

   // Bits of the event register that hold a flag.
   localparam logic [DATA_W-1:0] EVENT_VALID = 32'h0000007D;
   // Bits of the shared mask that hold an enable or the master gate.
   localparam logic [DATA_W-1:0] MASK_VALID = 32'h8000007D;
   // Reset value of both the mask and the event flags.
   localparam logic [DATA_W-1:0] REG_RESET = 32'h00000000;
   // Value returned for reads of unmapped codes.
   localparam logic [DATA_W-1:0] READ_NONE = 32'h00000000;

endpackage : irq_mask_pkg

//--- core/irq_event_store.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky event flags; hardware sets them, only software clears them.
module irq_event_store
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Requests from the register logic and flag contents.
   irq_flag_if.store fl
);

   // Flag contents.
   logic [irq_mask_pkg::DATA_W-1:0] flags;
   // Next value of each flag.
   logic [irq_mask_pkg::DATA_W-1:0] next_flags;

   // Each flag bit is computed alike; a set in the clearing cycle wins.
   genvar i;
   generate
      for (i = 0; i < irq_mask_pkg::DATA_W; i = i + 1)
      begin : g_flag
         // Reserved positions never hold a flag.
         assign next_flags[i] = irq_mask_pkg::EVENT_VALID[i]
            & (fl.set_vec[i] | (flags[i] & ~fl.clr_vec[i]));
      end
   endgenerate

   // Flag register, frozen while the clock enable is low.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         flags <= irq_mask_pkg::REG_RESET;
      end
      else if (fl.ce)
      begin
         // Software reset clears the flags.
         if (fl.soft_clr)
         begin
            flags <= irq_mask_pkg::REG_RESET;
         end
         else
         begin
            flags <= next_flags;
         end
      end
   end

   assign fl.flags = flags;

endmodule : irq_event_store
`default_nettype wire

//--- core/usb_host_interrupt_mask.sv
`timescale 1ns/1ps
`default_nettype none
// Interrupt mask block of the host controller.  Software reaches the event
// register and the shared mask through command codes on a plain register
// port.  The mask is written through a set-style and a clear-style code
// and both read back the same value.  The interrupt request is the OR of
// flags that are both enabled and let through by the master gate.
module usb_host_interrupt_mask
#(
   // Width of the data path.
   parameter int DATA_W = irq_mask_pkg::DATA_W,
   // Width of a command code.
   parameter int CMD_W = irq_mask_pkg::CMD_W
)
(
   // Clock, reset and clock enable.
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   // Software reset request from the controller, one cycle.
   input wire logic soft_reset,
   // Event pulses, one per event field position.
   input wire logic [DATA_W-1:0] event_in,
   // Register port.
   input wire logic [CMD_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Interrupt request to the host bus, active high level.
   output logic irq
);

   // Link to the event flag store.
   irq_flag_if fl ();

   // Shared mask of enables and the master gate.
   logic [DATA_W-1:0] irq_mask;
   // Next value of the shared mask.
   logic [DATA_W-1:0] next_irq_mask;
   // Next read data value.
   logic [DATA_W-1:0] next_rdata;
   // Next interrupt request level.
   logic next_irq;

   // Decoded write commands.
   wire wr_event = reg_wr && (reg_addr == irq_mask_pkg::CMD_EVENT_WR);
   wire wr_set = reg_wr && (reg_addr == irq_mask_pkg::CMD_MASK_SET_WR);
   wire wr_clr = reg_wr && (reg_addr == irq_mask_pkg::CMD_MASK_CLR_WR);

   // Decoded read commands.
   wire rd_event = reg_rd && (reg_addr == irq_mask_pkg::CMD_EVENT_RD);
   wire rd_set = reg_rd && (reg_addr == irq_mask_pkg::CMD_MASK_SET_RD);
   wire rd_clr = reg_rd && (reg_addr == irq_mask_pkg::CMD_MASK_CLR_RD);

   // Bits that a set-style write sets.
   wire [DATA_W-1:0] set_bits = wr_set ? reg_wdata : irq_mask_pkg::REG_RESET;
   // Bits that a clear-style write clears.
   wire [DATA_W-1:0] clr_bits = wr_clr ? reg_wdata : irq_mask_pkg::REG_RESET;

   // Per-bit mask update; zero data bits leave the enable unchanged and
   // reserved positions stay zero.
   genvar i;
   generate
      for (i = 0; i < DATA_W; i = i + 1)
      begin : g_mask
         assign next_irq_mask[i] = irq_mask_pkg::MASK_VALID[i]
            & (set_bits[i] | (irq_mask[i] & ~clr_bits[i]));
      end
   endgenerate

   // Event pulses set flags at valid positions only.
   assign fl.set_vec = event_in & irq_mask_pkg::EVENT_VALID;
   // Software clears flags by writing ones, and a status read clears the
   // flags it returned; a new event in the same cycle still wins.
   assign fl.clr_vec = (wr_event ? reg_wdata : irq_mask_pkg::REG_RESET)
      | (rd_event ? fl.flags : irq_mask_pkg::REG_RESET);
   // Software reset also clears the flags.
   assign fl.soft_clr = soft_reset;
   // The store freezes with the rest of the block.
   assign fl.ce = ce;

   // Read data selection; both mask codes return the same shared mask and
   // unmapped codes return zero.
   assign next_rdata = rd_event ? fl.flags
      : (rd_set || rd_clr) ? irq_mask
      : irq_mask_pkg::READ_NONE;

   // Interrupt needs an enabled flag and the master gate.
   assign next_irq = irq_mask[irq_mask_pkg::MASTER_IRQ_GATE_BIT]
      && ((fl.flags & irq_mask & irq_mask_pkg::EVENT_VALID)
         != irq_mask_pkg::REG_RESET);

   // Event flag store.
   irq_event_store u_store
   (
      .core_clk (core_clk),
      .rstn (rstn),
      .fl (fl.store)
   );

   // Shared mask register; software reset returns it to the blocking state.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_mask <= irq_mask_pkg::REG_RESET;
      end
      else if (ce)
      begin
         if (soft_reset)
         begin
            irq_mask <= irq_mask_pkg::REG_RESET;
         end
         else
         begin
            irq_mask <= next_irq_mask;
         end
      end
   end

   // Read data register; data stand only in the cycle after the read.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_rdata <= irq_mask_pkg::READ_NONE;
      end
      else if (ce)
      begin
         reg_rdata <= next_rdata;
      end
   end

   // Interrupt request register, refreshed every enabled clock.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irq <= 1'b0;
      end
      else if (ce)
      begin
         // Software reset drops the request along with the mask.
         if (soft_reset)
         begin
            irq <= 1'b0;
         end
         else
         begin
            irq <= next_irq;
         end
      end
   end

endmodule : usb_host_interrupt_mask
`default_nettype wire

//--- verif/host_bus.sv
`timescale 1ns/1ps
`default_nettype none
// Host processor on the register port; one-cycle strobes only.
module host_bus (
   input wire logic core_clk,
   input wire logic [31:0] reg_rdata,
   output logic [7:0] reg_addr = 8'h7F,
   output logic [31:0] reg_wdata = 32'h0,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0
);
   // One write; released lines show the inverse, not stale values.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   // One read; the data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(negedge core_clk);
      d = reg_rdata;
   endtask : rd
endmodule : host_bus
`default_nettype wire

//--- verif/irq_mask_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Tracks the mask and the event flags from the port traffic alone.
module irq_mask_checker (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic soft_reset,
   input wire logic [31:0] event_in,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic irq
);
   // Shadow copies of the shared mask and of the event flags.
   logic [31:0] mask;
   logic [31:0] flag;
   // Flags that software clears this cycle, by write or by read.
   wire logic [31:0] clr = (ce && reg_wr && reg_addr == 8'h83) ? reg_wdata
      : (ce && reg_rd && reg_addr == 8'h03) ? flag : 32'h0;
   // Level that the request output must take one cycle later.
   wire logic want = mask[31] && |(flag & mask & 32'h0000007D);
   // Updates the shadows; a set event wins over a clear.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mask <= 32'h0;
         flag <= 32'h0;
      end
      else if (ce && soft_reset)
      begin
         mask <= 32'h0;
         flag <= 32'h0;
      end
      else if (ce)
      begin
         flag <= (flag & ~clr) | (event_in & 32'h0000007D);
         if (reg_wr && reg_addr == 8'h84)
            mask <= mask | (reg_wdata & 32'h8000007D);
         else if (reg_wr && reg_addr == 8'h85)
            mask <= mask & ~reg_wdata;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_set_read: assert property (ce && reg_rd && reg_addr == 8'h04
      |=> reg_rdata == $past(mask)) else $error("set-style read wrong");
   a_clr_read: assert property (ce && reg_rd && reg_addr == 8'h05
      |=> reg_rdata == $past(mask)) else $error("clear-style read wrong");
   a_event_read: assert property (ce && reg_rd && reg_addr == 8'h03
      |=> reg_rdata == $past(flag)) else $error("event read wrong");
   a_none_read: assert property (ce && reg_rd &&
      !(reg_addr inside {8'h03, 8'h04, 8'h05}) |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_idle: assert property (ce && !reg_rd |=> !reg_rdata)
      else $error("read data left standing");
   a_irq_level: assert property (ce && !soft_reset |=> irq == $past(want))
      else $error("interrupt level wrong");
   a_soft_clear: assert property (ce && soft_reset |=> !irq [*2])
      else $error("interrupt survives soft reset");
   a_rsv_zero: assert property ((reg_rdata & 32'h7FFFFF82) == 32'h0)
      else $error("reserved bits read nonzero");
endmodule : irq_mask_checker
bind usb_host_interrupt_mask irq_mask_checker u_irq_mask_checker (
   .core_clk(core_clk), .rstn(rstn), .ce(ce), .soft_reset(soft_reset),
   .event_in(event_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

//--- verif/usb_host_interrupt_mask_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
   bad_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module usb_host_interrupt_mask_tb;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic soft_reset = 1'b0;
   logic ce = 1'b1;
   logic [31:0] event_in = 32'h0;
   wire logic [7:0] reg_addr;
   wire logic [31:0] reg_wdata;
   wire logic reg_wr;
   wire logic reg_rd;
   wire logic [31:0] reg_rdata;
   wire logic irq;
   int bad_count = 0;
   int n_tests = 0;
   always #20 core_clk = ~core_clk;
   usb_host_interrupt_mask u_usb_host_interrupt_mask (.core_clk(core_clk),
      .rstn(rstn), .ce(ce), .soft_reset(soft_reset), .event_in(event_in),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   host_bus u_host_bus (.core_clk(core_clk), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd));
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      u_host_bus.wr(a, d);
   endtask : w
   // Reads one code and compares the word.
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      u_host_bus.rd(a, d);
      `CHK("rdata", e, d)
   endtask : rc
   // Lets the last change reach the registered request, then looks.
   task automatic ic(input logic e);
      @(posedge core_clk);
      @(negedge core_clk);
      `CHK("irq", e, irq)
   endtask : ic
   // One-cycle event pulse.
   task automatic ev(input int b);
      @(posedge core_clk);
      event_in <= 32'h1 << b;
      @(posedge core_clk);
      event_in <= 32'h0;
   endtask : ev
   task automatic t_reset;
      rc(8'h04, 32'h0);
      rc(8'h05, 32'h0);
      ic(1'b0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_mask;
      w(8'h84, 32'hFFFFFFFF);
      rc(8'h04, 32'h8000007D);
      rc(8'h05, 32'h8000007D);
      w(8'h85, 32'h0000000C);
      rc(8'h04, 32'h80000071);
      w(8'h84, 32'h0);
      rc(8'h04, 32'h80000071);
      w(8'h85, 32'h80000000);
      rc(8'h05, 32'h00000071);
      rc(8'h06, 32'h0);
      w(8'h85, 32'hFFFFFFFF);
      rc(8'h04, 32'h0);
      $display("t_mask done");
   endtask : t_mask
   // Each event alone, with its enable set: gated by the master gate and cleared by a write of one.
   task automatic t_irq;
      int pos[6] = '{0, 2, 3, 4, 5, 6};
      foreach (pos[i])
      begin
         w(8'h84, 32'h1 << pos[i]);
         ev(pos[i]);
         ic(1'b0);
         w(8'h84, 32'h80000000);
         ic(1'b1);
         w(8'h85, 32'h80000000);
         ic(1'b0);
         w(8'h84, 32'h80000000);
         ic(1'b1);
         w(8'h83, 32'h1 << pos[i]);
         ic(1'b0);
         w(8'h85, 32'hFFFFFFFF);
      end
      w(8'h84, 32'hFFFFFFFF);
      ev(1);
      ic(1'b0);
      $display("t_irq done");
   endtask : t_irq
   task automatic t_soft;
      ev(6);
      ic(1'b1);
      @(posedge core_clk);
      soft_reset <= 1'b1;
      @(posedge core_clk);
      soft_reset <= 1'b0;
      ic(1'b0);
      rc(8'h04, 32'h0);
      rc(8'h03, 32'h0);
      $display("t_soft done");
   endtask : t_soft
   // A low clock enable must drop writes and events alike.
   task automatic t_ce;
      w(8'h84, 32'h80000004);
      @(posedge core_clk);
      ce <= 1'b0;
      w(8'h85, 32'h80000004);
      ev(2);
      @(posedge core_clk);
      ce <= 1'b1;
      rc(8'h04, 32'h80000004);
      rc(8'h03, 32'h0);
      ic(1'b0);
      w(8'h85, 32'hFFFFFFFF);
      $display("t_ce done");
   endtask : t_ce
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   initial
   begin
      #200000;
      bad_count++;
      close_out();
   end
   initial
   begin
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_mask();
      t_irq();
      t_soft();
      t_ce();
      close_out();
   end
endmodule : usb_host_interrupt_mask_tb
`default_nettype wire
